// ==== hw/bcpm_pkg.sv ====
package bcpm_pkg;
    // dword offsets in configuration space
    localparam logic [7:0] off_intr_bctl = 8'h3c;
    localparam logic [7:0] off_pm_cap = 8'h80;
    // field positions within the 0x3c dword
    localparam int intr_line_lsb = 0;
    localparam int intr_pin_lsb = 8;
    localparam int poison_resp_bit = 16;
    localparam int err_forward_bit = 17;
    localparam int legacy_io_bit = 18;
    localparam int vga_en_bit = 19;
    localparam int vga_16bit_bit = 20;
    localparam int sec_reset_bit = 22;
    // field positions within the 0x80 dword
    localparam int cap_id_lsb = 0;
    localparam int next_cap_lsb = 8;
    // reset and fixed values
    localparam logic [7:0] intr_line_rst = 8'h00;
    localparam logic [7:0] intr_pin_rst = 8'h00;
    localparam logic [7:0] pm_cap_id = 8'h01;
    localparam logic [7:0] next_cap_up = 8'h9c;
    localparam logic [7:0] next_cap_down = 8'h8c;
    // legacy window limits
    localparam logic [31:0] vga_mem_lo = 32'h000a_0000;
    localparam logic [31:0] vga_mem_hi = 32'h000b_ffff;
    localparam logic [9:0] vga_io_a_lo = 10'h3b0;
    localparam logic [9:0] vga_io_a_hi = 10'h3bb;
    localparam logic [9:0] vga_io_b_lo = 10'h3c0;
    localparam logic [9:0] vga_io_b_hi = 10'h3df;
    localparam logic [9:0] legacy_io_top_lo = 10'h100;
endpackage

// ==== hw/bcpm_regs.sv ====
// Operation
// - The interrupt pin byte is read only, resets to zero and may take a strap default on downstream ports.
// - Control bit 16 makes poisoned TLPs on the secondary side ignored when clear and reported when set.
// - Control bit 17 blocks error message forwarding upstream when clear and allows it when set, reset zero.
// - Control bit 18 sends I/O in range, below 64KB and in the top 768 bytes of each 1KB, upstream.
// - Control bit 19 forwards accesses to the legacy VGA memory window when set, ignores them when clear.
// - A VGA I/O access lies below 64KB with low ten bits in 3B0h-3BBh or 3C0h-3DFh.
// - Control bit 20 selects a 10-bit VGA I/O decode when clear and a 16-bit decode when set.
// - On port 2 the VGA enable and VGA 16-bit decode bits are reserved.
// - Setting control bit 22 triggers a hot reset on the port, clearing it does not, reset zero.
// - The reset drives this port's output on a downstream port and every downstream output on the upstream port.
// - Control bits 21 and 23 to 27 are hardwired zero and ignore writes.
// - The power management capability ID byte is read only and returns 01h.
// - The next capability pointer is read only, 9Ch on upstream ports and 8Ch on downstream ports.
`timescale 1ns/100ps
module bcpm_regs #(
    parameter int num_down = 3,
    parameter bit is_upstream = 1'h0,
    parameter bit is_port2 = 1'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] strap_intr_pin,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_be,
    output logic [31:0] cfg_rdata,
    output logic cfg_rd_valid,
    input wire logic io_req,
    input wire logic [31:0] io_addr,
    input wire logic io_in_window,
    output logic io_forward_up,
    output logic io_forward_down,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic vga_forward,
    input wire logic poison_seen,
    output logic poison_report,
    input wire logic sec_err_msg,
    output logic err_msg_forward,
    output logic [num_down-1:0] port_reset
);
    logic [7:0] intr_line;
    logic [7:0] intr_pin;
    logic poison_resp;
    logic secondary_error_forward_en;
    logic legacy_io_block_mode;
    logic vga_en;
    logic vga_16bit;
    logic sec_reset;
    logic strap_done;
    logic [15:0] bctl;
    logic [31:0] next_rdata;
    logic sel_bctl;
    logic vga_io_hit;
    logic legacy_io_hit;

    assign sel_bctl = cfg_wr && (cfg_addr == bcpm_pkg::off_intr_bctl);

    always_comb begin
        bctl = 16'h0000;
        bctl[bcpm_pkg::poison_resp_bit-16] = poison_resp;
        bctl[bcpm_pkg::err_forward_bit-16] = secondary_error_forward_en;
        bctl[bcpm_pkg::legacy_io_bit-16] = legacy_io_block_mode;
        bctl[bcpm_pkg::vga_en_bit-16] = vga_en;
        bctl[bcpm_pkg::vga_16bit_bit-16] = vga_16bit;
        bctl[bcpm_pkg::sec_reset_bit-16] = sec_reset;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intr_line <= bcpm_pkg::intr_line_rst;
        end else if (sel_bctl && cfg_be[0]) begin
            intr_line <= cfg_wdata[7:0];
        end
    end

    // strap taken once after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intr_pin <= bcpm_pkg::intr_pin_rst;
            strap_done <= 1'h0;
        end else if (!strap_done) begin
            strap_done <= 1'h1;
            intr_pin <= is_upstream ? bcpm_pkg::intr_pin_rst : strap_intr_pin;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            poison_resp <= 1'h0;
            secondary_error_forward_en <= 1'h0;
            legacy_io_block_mode <= 1'h0;
            sec_reset <= 1'h0;
        end else if (sel_bctl && cfg_be[2]) begin
            poison_resp <= cfg_wdata[bcpm_pkg::poison_resp_bit];
            secondary_error_forward_en <= cfg_wdata[bcpm_pkg::err_forward_bit];
            legacy_io_block_mode <= cfg_wdata[bcpm_pkg::legacy_io_bit];
            sec_reset <= cfg_wdata[bcpm_pkg::sec_reset_bit];
        end
    end

    // vga bits reserved on port 2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vga_en <= 1'h0;
            vga_16bit <= 1'h0;
        end else if (sel_bctl && cfg_be[2] && !is_port2) begin
            vga_en <= cfg_wdata[bcpm_pkg::vga_en_bit];
            vga_16bit <= cfg_wdata[bcpm_pkg::vga_16bit_bit];
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (cfg_addr == bcpm_pkg::off_intr_bctl) begin
            next_rdata = {bctl, intr_pin, intr_line};
        end else if (cfg_addr == bcpm_pkg::off_pm_cap) begin
            next_rdata[15:8] = is_upstream ? bcpm_pkg::next_cap_up : bcpm_pkg::next_cap_down;
            next_rdata[7:0] = bcpm_pkg::pm_cap_id;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_rd_valid <= 1'h0;
        end else begin
            cfg_rd_valid <= cfg_rd;
            cfg_rdata <= cfg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    always_comb begin
        vga_io_hit = ((io_addr[9:0] >= bcpm_pkg::vga_io_a_lo) &&
                      (io_addr[9:0] <= bcpm_pkg::vga_io_a_hi)) ||
                     ((io_addr[9:0] >= bcpm_pkg::vga_io_b_lo) &&
                      (io_addr[9:0] <= bcpm_pkg::vga_io_b_hi));
        vga_io_hit = vga_io_hit && (io_addr[31:16] == 16'h0000) &&
                     (!vga_16bit || (io_addr[15:10] == 6'h00));
        // top 768 bytes of each 1KB below 64KB
        legacy_io_hit = legacy_io_block_mode && (io_addr[31:16] == 16'h0000) &&
                        (io_addr[9:0] >= bcpm_pkg::legacy_io_top_lo);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_forward_up <= 1'h0;
            io_forward_down <= 1'h0;
            vga_forward <= 1'h0;
        end else begin
            io_forward_up <= io_req && io_in_window && legacy_io_hit;
            io_forward_down <= io_req && ((io_in_window && !legacy_io_hit) ||
                                          (vga_en && vga_io_hit));
            vga_forward <= vga_en && ((mem_req && (mem_addr >= bcpm_pkg::vga_mem_lo) &&
                                       (mem_addr <= bcpm_pkg::vga_mem_hi)) ||
                                      (io_req && vga_io_hit));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            poison_report <= 1'h0;
            err_msg_forward <= 1'h0;
        end else begin
            poison_report <= poison_seen && poison_resp;
            err_msg_forward <= sec_err_msg && secondary_error_forward_en;
        end
    end

    for (genvar i = 0; i < num_down; i++) begin : g_rst
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                port_reset[i] <= 1'h0;
            end else begin
                port_reset[i] <= sec_reset && (is_upstream || i == 0);
            end
        end
    end

    property p_err_gate;
        @(posedge clk) disable iff (rst)
        err_msg_forward |-> $past(sec_err_msg) && $past(secondary_error_forward_en);
    endproperty
    a_err_gate: assert property (p_err_gate) else $error("error forwarded while gated");

    property p_poison;
        @(posedge clk) disable iff (rst)
        (poison_seen && poison_resp) |=> poison_report;
    endproperty
    a_poison: assert property (p_poison) else $error("poisoned tlp not reported");

    property p_hard_zero;
        @(posedge clk) disable iff (rst)
        cfg_rd_valid && $past(cfg_addr) == bcpm_pkg::off_intr_bctl |-> cfg_rdata[31:23] == 9'h000
            && !cfg_rdata[21];
    endproperty
    a_hard_zero: assert property (p_hard_zero) else $error("hardwired bits not zero");

    property p_cap_id;
        @(posedge clk) disable iff (rst)
        cfg_rd && cfg_addr == bcpm_pkg::off_pm_cap |=> cfg_rdata[7:0] == 8'h01;
    endproperty
    a_cap_id: assert property (p_cap_id) else $error("capability id wrong");

    property p_next_cap;
        @(posedge clk) disable iff (rst)
        cfg_rd && cfg_addr == bcpm_pkg::off_pm_cap |=>
            cfg_rdata[15:8] == (is_upstream ? 8'h9c : 8'h8c);
    endproperty
    a_next_cap: assert property (p_next_cap) else $error("next pointer wrong");

    property p_reset_out;
        @(posedge clk) disable iff (rst)
        sec_reset |=> port_reset[0];
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("port reset not driven");

    property p_reset_clear;
        @(posedge clk) disable iff (rst)
        !sec_reset |=> port_reset == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("port reset without bit");

    property p_port2;
        @(posedge clk) disable iff (rst)
        is_port2 |-> !vga_en && !vga_16bit;
    endproperty
    a_port2: assert property (p_port2) else $error("vga bits set on port 2");

    property p_vga_off;
        @(posedge clk) disable iff (rst)
        !vga_en |=> !vga_forward;
    endproperty
    a_vga_off: assert property (p_vga_off) else $error("vga forwarded while disabled");

    property p_legacy_up;
        @(posedge clk) disable iff (rst)
        !legacy_io_block_mode |=> !io_forward_up;
    endproperty
    a_legacy_up: assert property (p_legacy_up) else $error("io sent up without mode");

    property p_poison_off;
        @(posedge clk) disable iff (rst)
        !poison_resp |=> !poison_report;
    endproperty
    a_poison_off: assert property (p_poison_off)
        else $error("poison reported while ignored");

    property p_err_fwd;
        @(posedge clk) disable iff (rst)
        sec_err_msg && secondary_error_forward_en |=> err_msg_forward;
    endproperty
    a_err_fwd: assert property (p_err_fwd)
        else $error("error message not forwarded");

    property p_up_window;
        @(posedge clk) disable iff (rst)
        io_forward_up |-> $past(io_req) && $past(io_in_window);
    endproperty
    a_up_window: assert property (p_up_window)
        else $error("io sent up outside the window");

    property p_legacy_down;
        @(posedge clk) disable iff (rst)
        io_req && io_in_window && !legacy_io_block_mode |=> io_forward_down;
    endproperty
    a_legacy_down: assert property (p_legacy_down)
        else $error("io in window not sent down");

    property p_vga_mem;
        @(posedge clk) disable iff (rst)
        vga_en && mem_req && mem_addr >= bcpm_pkg::vga_mem_lo &&
            mem_addr <= bcpm_pkg::vga_mem_hi |=> vga_forward;
    endproperty
    a_vga_mem: assert property (p_vga_mem)
        else $error("vga memory access not forwarded");

    property p_vga_io;
        @(posedge clk) disable iff (rst)
        vga_en && io_req && io_addr[31:10] == 22'h0 &&
            io_addr[9:0] >= bcpm_pkg::vga_io_b_lo && io_addr[9:0] <= bcpm_pkg::vga_io_b_hi
            |=> vga_forward && io_forward_down;
    endproperty
    a_vga_io: assert property (p_vga_io)
        else $error("vga io access not forwarded");

    property p_vga_16;
        @(posedge clk) disable iff (rst)
        vga_16bit && io_req && !io_in_window && io_addr[15:10] != 6'h00 |=> !io_forward_down;
    endproperty
    a_vga_16: assert property (p_vga_16)
        else $error("vga io decoded on ten bits in wide mode");

    property p_pin_ro;
        @(posedge clk) disable iff (rst)
        strap_done && cfg_wr |=> $stable(intr_pin);
    endproperty
    a_pin_ro: assert property (p_pin_ro)
        else $error("interrupt pin changed by a write");

    property p_reset_all;
        @(posedge clk) disable iff (rst)
        is_upstream && sec_reset |=> &port_reset;
    endproperty
    a_reset_all: assert property (p_reset_all)
        else $error("upstream reset not sent to every port");

    property p_reset_own;
        @(posedge clk) disable iff (rst)
        !is_upstream |-> (port_reset >> 1) == '0;
    endproperty
    a_reset_own: assert property (p_reset_own)
        else $error("downstream port drove another port reset");
endmodule

// ==== verification/bcpm_host.sv ====
`timescale 1ns/100ps
module bcpm_host (
    input wire logic clk,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    output logic [3:0] cfg_be,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rd_valid
);
    initial begin
        cfg_wr = 1'h0;
        cfg_rd = 1'h0;
        cfg_addr = 8'h00;
        cfg_wdata = 32'h0;
        cfg_be = 4'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        cfg_wr <= 1'h1;
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_be <= be;
        @(posedge clk);
        cfg_wr <= 1'h0;
        // released lines stop showing the old value
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        cfg_rd <= 1'h1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'h0;
        cfg_addr <= ~a;
        @(negedge clk);
        d = (cfg_rd_valid === 1'h1) ? cfg_rdata : 32'hxxxx_xxxx;
    endtask
endmodule

// ==== verification/bridge_control_pm_cap_header_tb.sv ====
`timescale 1ns/100ps
module bridge_control_pm_cap_header_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cfg_wr, cfg_rd, cfg_rd_valid, io_req = 1'h0, io_in_window = 1'h0;
    logic mem_req = 1'h0, poison_seen = 1'h0, sec_err_msg = 1'h0;
    logic io_forward_up, io_forward_down, vga_forward, poison_report, err_msg_forward;
    logic [7:0] cfg_addr;
    logic [7:0] strap_intr_pin = 8'h01;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, d;
    logic [31:0] io_addr = 32'h0, mem_addr = 32'h0;
    logic [2:0] port_reset;
    logic up_valid, up_vga;
    logic [31:0] up_rdata;
    logic [2:0] up_reset;
    int failures = 0;
    int check_count = 0;

    always #2.5 clk = ~clk;

    bcpm_host host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid));

    bcpm_regs DUT (.clk(clk), .rst(rst), .strap_intr_pin(strap_intr_pin), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
        .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .io_req(io_req),
        .io_addr(io_addr), .io_in_window(io_in_window), .io_forward_up(io_forward_up),
        .io_forward_down(io_forward_down), .mem_req(mem_req), .mem_addr(mem_addr),
        .vga_forward(vga_forward), .poison_seen(poison_seen), .poison_report(poison_report),
        .sec_err_msg(sec_err_msg), .err_msg_forward(err_msg_forward),
        .port_reset(port_reset));

    // upstream port 2: strap ignored, vga bits reserved, reset fans out to all ports
    bcpm_regs #(.num_down(3), .is_upstream(1'h1), .is_port2(1'h1)) up_port (.clk(clk),
        .rst(rst), .strap_intr_pin(strap_intr_pin), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(up_rdata),
        .cfg_rd_valid(up_valid), .io_req(io_req), .io_addr(io_addr),
        .io_in_window(io_in_window), .io_forward_up(), .io_forward_down(), .mem_req(mem_req),
        .mem_addr(mem_addr), .vga_forward(up_vga), .poison_seen(poison_seen),
        .poison_report(), .sec_err_msg(sec_err_msg), .err_msg_forward(),
        .port_reset(up_reset));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // order of the result bits: poison, error, vga, up, down
    task automatic probe(input logic [31:0] ia, input logic win, input logic [31:0] ma,
            input logic [4:0] exp, input logic [4:0] mask);
        @(posedge clk);
        io_req <= 1'h1;
        io_addr <= ia;
        io_in_window <= win;
        mem_req <= 1'h1;
        mem_addr <= ma;
        poison_seen <= 1'h1;
        sec_err_msg <= 1'h1;
        @(posedge clk);
        io_req <= 1'h0;
        mem_req <= 1'h0;
        poison_seen <= 1'h0;
        sec_err_msg <= 1'h0;
        @(negedge clk);
        chk("decode", {27'h0, exp & mask}, {27'h0, mask & {poison_report, err_msg_forward,
            vga_forward, io_forward_up, io_forward_down}});
        chk("up_vga", 32'h0, {31'h0, up_vga});
    endtask

    task automatic chk_rst(input logic [2:0] exp, input logic [2:0] exp_up);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("port_reset", {29'h0, exp}, {29'h0, port_reset});
        chk("up_port_reset", {29'h0, exp_up}, {29'h0, up_reset});
    endtask

    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        host.rd(8'h3c, d);
        chk("dw3c", 32'h0000_0100, d);
        chk("up_dw3c", 32'h0000_0000, up_rdata);
        chk("up_valid", 32'h0000_0001, {31'h0, up_valid});
        host.rd(8'h80, d);
        chk("dw80", 32'h0000_8c01, d);
        chk("up_dw80", 32'h0000_9c01, up_rdata);
        host.rd(8'h40, d);
        chk("dw40", 32'h0, d);
        $display("test reset values done");
        host.wr(8'h3c, 32'hffff_ffff, 4'hf);
        chk_rst(3'h1, 3'h7);
        host.rd(8'h3c, d);
        chk("dw3c", 32'h005f_01ff, d);
        chk("up_dw3c", 32'h0047_00ff, up_rdata);
        host.wr(8'h80, 32'hffff_ffff, 4'hf);
        host.rd(8'h80, d);
        chk("dw80", 32'h0000_8c01, d);
        chk("up_dw80", 32'h0000_9c01, up_rdata);
        $display("test field access done");
        probe(32'h0000_0100, 1'h1, 32'h000a_0000, 5'h1e, 5'h1f);
        probe(32'h0000_07b0, 1'h0, 32'h000c_0000, 5'h18, 5'h1f);
        probe(32'h0000_03df, 1'h0, 32'h000c_0000, 5'h1d, 5'h1f);
        host.wr(8'h3c, 32'h0008_0000, 4'h4);
        chk_rst(3'h0, 3'h0);
        probe(32'h0000_07b0, 1'h0, 32'h000c_0000, 5'h05, 5'h1f);
        probe(32'h0000_0100, 1'h1, 32'h000b_ffff, 5'h05, 5'h1f);
        host.wr(8'h3c, 32'h0, 4'h4);
        probe(32'h0000_03b0, 1'h0, 32'h000a_0000, 5'h00, 5'h1f);
        $display("test decode done");
        host.wr(8'h3c, 32'hffff_ffff, 4'hf);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        host.rd(8'h3c, d);
        chk("dw3c", 32'h0000_0100, d);
        chk("up_dw3c", 32'h0000_0000, up_rdata);
        $display("test second reset done");
        summarize();
    end
endmodule
